// >>> hdl/ssf_cfg.svh
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH
// Overview of operation
// - Frames of 4 to 16 bits, MSB first
// - Frame-pulse, SPI and half-duplex framings selectable
// - Serial clock idles inactive, toggles only in frames
// - Idle clock plus unread receive data raises timeout
// - SPI/half-duplex select low throughout each frame
// - Frame-pulse select high one period before frame
// - Frame-pulse drives on rising, samples on falling
// - Half-duplex: 8-bit command, wait, 4-16 reply bits
// - Frame-pulse idle: clock, select low, transmit floating
// - Frame-pulse: pulse select, load shifter, MSB next rise
// - Frame-pulse: receive word pushed on following rise
// - SPI clock rests at polarity bit level
// - Phase bit picks first or second capture edge
// - SPI idle: select high, transmit low, clock pad
// - SPI master start: select low, transmit pad on
// - Polarity0 phase0: data half period, then clock
// - Select returns high one period after last capture
// - Phase0 back-to-back: select pulses high between words
// - Phase1: data and first edge half period in
// - Phase1 back-to-back: select stays low between words
// - Polarity1 phase0: clock falls first, same timing

`define SSF_FMT_PULSE 2'h0
`define SSF_FMT_SPI 2'h1
`define SSF_FMT_HALFDUP 2'h2
`define SSF_SIZE_MIN_M1 4'h3
`define SSF_CTRL_BITS 8
`define SSF_MW_CTRL_LAST_H 6'h0E
`define SSF_MW_TX_OFF_H 6'h10
`define SSF_MW_FIRST_CAP_H 6'h13
`define SSF_MW_TAIL_H 6'h13
`define SSF_MW_WIN_TAIL 6'h12
`define SSF_MW_CAP_TAIL 6'h11
`define SSF_SPI_TAIL_H 6'h02
`define SSF_HALF_DIV 4
`define SSF_RX_TIMEOUT_CYC 64
`endif

// >>> hdl/ssf_pkg.sv
package ssf_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_GAP
   } ssf_state_t;
endpackage

// >>> hdl/ssf_sync2.sv
`timescale 1ns/1ps
module ssf_sync2 #(
   parameter int WIDTH = 3
) (
   // System
   input wire logic clk,
   input wire logic resetn,
   // Crossing
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1_reg <= '0;
         syncOut <= '0;
      end else begin
         stage1_reg <= asyncIn;
         syncOut <= stage1_reg;
      end
   end
endmodule

// >>> hdl/ssf_frame_engine.sv
`timescale 1ns/1ps
`include "ssf_cfg.svh"
module ssf_frame_engine import ssf_pkg::*; #(
   parameter int HALF_DIV = `SSF_HALF_DIV,
   parameter int TIMEOUT_CYC = `SSF_RX_TIMEOUT_CYC
) (
   // System
   input wire logic clk,
   input wire logic resetn,
   // Configuration
   input wire logic enable,
   input wire logic masterMode,
   input wire logic [1:0] frameFormat,
   input wire logic clockPolarityBit,
   input wire logic clockPhaseBit,
   input wire logic [3:0] dataSizeMinus1,
   // Transmit FIFO side
   input wire logic txValid,
   input wire logic [15:0] txData,
   output logic txPop,
   // Receive FIFO side
   output logic rxPush,
   output logic [15:0] rxWord,
   input wire logic rxFifoNotEmpty,
   output logic rxTimeout,
   output logic busy,
   // Serial clock pin
   input wire logic serialClockIn,
   output logic serialClockOut,
   output logic serialClockOe,
   // Frame select pin
   input wire logic frameSelectIn,
   output logic frameSelectOut,
   output logic frameSelectOe,
   // Data pins
   output logic serialTransmitOut,
   output logic serialTransmitOe,
   input wire logic serialReceiveIn
);
   localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);
   localparam logic [15:0] TOUT_LAST = 16'(TIMEOUT_CYC - 1);

   function automatic logic inRange(input logic [5:0] h, input logic [5:0] lo, input logic [5:0] hi);
      inRange = (h >= lo) && (h <= hi);
   endfunction

   function automatic logic [15:0] alignWord(input logic [15:0] d, input logic mw, input logic [3:0] bits);
      alignWord = mw ? {d[7:0], 8'h00} : (d << (4'hF - bits));
   endfunction

   ssf_state_t stateReg;
   logic [7:0] div_reg;
   logic [5:0] half_reg;
   logic [3:0] bits_reg;
   logic [15:0] txShift_reg;
   logic [15:0] rxShift_reg;
   logic [15:0] tout_reg;
   logic sclkPrev_reg;
   logic fssPrev_reg;
   logic [2:0] pinSync;

   // Pins cross into clk before any logic looks at them
   ssf_sync2 #(.WIDTH(3)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .asyncIn({serialClockIn, frameSelectIn, serialReceiveIn}),
      .syncOut(pinSync)
   );

   wire logic sclkSync = pinSync[2];
   wire logic fssSync = pinSync[1];
   wire logic rxSync = pinSync[0];

   wire logic isTi = (frameFormat == `SSF_FMT_PULSE);
   wire logic isSpi = (frameFormat == `SSF_FMT_SPI);
   wire logic isMw = (frameFormat == `SSF_FMT_HALFDUP);
   wire logic idleClk = isSpi & clockPolarityBit;
   wire logic idleFss = ~isTi;
   wire logic [3:0] bitsNow = (dataSizeMinus1 < `SSF_SIZE_MIN_M1) ? `SSF_SIZE_MIN_M1 : dataSizeMinus1;
   wire logic [5:0] nBits = 6'(bits_reg) + 6'h01;
   wire logic [5:0] twoN = 6'(nBits << 1);
   wire logic [5:0] hN = half_reg + 6'h01;
   wire logic running = (stateReg == ST_RUN);
   wire logic slaveEdge = sclkSync ^ sclkPrev_reg;
   wire logic tick = (stateReg != ST_IDLE) & (masterMode ? (div_reg == DIV_LAST) : slaveEdge);
   wire logic [5:0] endH = isMw ? twoN + `SSF_MW_TAIL_H : twoN + `SSF_SPI_TAIL_H;
   wire logic endHit = masterMode & running & tick & (hN == endH);
   wire logic needGap = isSpi & ~clockPhaseBit;

   // Clock toggles only inside the frame window
   wire logic inWin = isTi ? inRange(hN, 6'h00, twoN + 6'h01) :
                      isMw ? inRange(hN, 6'h01, twoN + `SSF_MW_WIN_TAIL) :
                      clockPhaseBit ? inRange(hN, 6'h01, twoN) : inRange(hN, 6'h02, twoN + 6'h01);
   wire logic toggle = masterMode & running & tick & inWin;

   // Drive and capture points, counted in half periods from frame start
   wire logic emit = running & tick & (isSpi ? (hN[0] & (hN < twoN)) :
                     isTi ? (~hN[0] & inRange(hN, 6'h02, twoN)) :
                     (~hN[0] & inRange(hN, 6'h02, `SSF_MW_CTRL_LAST_H)));
   wire logic capture = running & tick & (isSpi ? (~hN[0] & inRange(hN, 6'h02, twoN)) :
                        isTi ? (hN[0] & inRange(hN, 6'h03, twoN + 6'h01)) :
                        (hN[0] & inRange(hN, `SSF_MW_FIRST_CAP_H, twoN + `SSF_MW_CAP_TAIL)));
   wire logic gapDone = (stateReg == ST_GAP) & tick & (hN == 6'h02);

   wire logic masterStart = masterMode & enable & txValid &
                            ((stateReg == ST_IDLE) | (endHit & ~needGap) | gapDone);
   wire logic slaveFall = ~masterMode & isSpi & enable & (stateReg == ST_IDLE) & fssPrev_reg & ~fssSync;
   wire logic slaveRise = ~masterMode & running & fssSync;
   wire logic [3:0] bitsLoad = masterStart | slaveFall ? bitsNow : bits_reg;
   // An empty FIFO in slave mode sends zeros rather than stale data
   wire logic [15:0] loadWord = (masterStart | txValid) ? alignWord(txData, isMw, bitsNow) : 16'h0000;
   wire logic emitNow = (masterStart & isMw) | (slaveFall & ~clockPhaseBit);
   wire logic [15:0] rxShiftNext = capture ? {rxShift_reg[14:0], rxSync} : rxShift_reg;
   wire logic [15:0] rxMask = 16'((17'h00001 << nBits) - 17'h00001);
   wire logic pushNow = masterMode ? endHit : (capture & (hN == twoN));

   assign txPop = masterStart | (slaveFall & txValid);
   assign busy = (stateReg != ST_IDLE);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stateReg <= ST_IDLE;
         half_reg <= 6'h00;
         div_reg <= 8'h00;
      end else if (!enable || slaveRise) begin
         stateReg <= ST_IDLE;
         half_reg <= 6'h00;
         div_reg <= 8'h00;
      end else if (masterStart) begin
         stateReg <= ST_RUN;
         half_reg <= 6'h00;
         div_reg <= 8'h00;
      end else if (slaveFall) begin
         stateReg <= ST_RUN;
         half_reg <= clockPhaseBit ? 6'h00 : 6'h01;
         div_reg <= 8'h00;
      end else begin
         case (stateReg)
            ST_IDLE: begin
               div_reg <= 8'h00;
            end
            ST_RUN: begin
               div_reg <= (div_reg == DIV_LAST) ? 8'h00 : div_reg + 8'h01;
               if (endHit) begin
                  stateReg <= (needGap & txValid) ? ST_GAP : ST_IDLE;
                  half_reg <= 6'h00;
               end else if (tick) begin
                  half_reg <= hN;
               end
            end
            ST_GAP: begin
               div_reg <= (div_reg == DIV_LAST) ? 8'h00 : div_reg + 8'h01;
               if (gapDone) begin
                  stateReg <= ST_IDLE;
               end else if (tick) begin
                  half_reg <= hN;
               end
            end
            default: begin
               stateReg <= ST_IDLE;
            end
         endcase
      end
   end

   // Serial clock: idle level, frame-pulse start edge, then window toggles
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         serialClockOut <= 1'b0;
         serialClockOe <= 1'b0;
      end else begin
         serialClockOe <= masterMode;
         if (masterStart & isTi) begin
            serialClockOut <= 1'b1;
         end else if (stateReg == ST_IDLE || stateReg == ST_GAP) begin
            serialClockOut <= idleClk;
         end else if (toggle) begin
            serialClockOut <= ~serialClockOut;
         end
      end
   end

   // Frame select is output only as master
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frameSelectOut <= 1'b0;
         frameSelectOe <= 1'b0;
      end else begin
         frameSelectOe <= masterMode;
         if (masterStart) begin
            frameSelectOut <= isTi;
         end else if (tick & running & isTi & (hN == 6'h02)) begin
            frameSelectOut <= 1'b0;
         end else if (endHit) begin
            frameSelectOut <= (needGap & txValid) ? 1'b1 : idleFss;
         end else if (stateReg == ST_IDLE || gapDone) begin
            frameSelectOut <= idleFss;
         end
      end
   end

   // Transmit shifter and pad
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txShift_reg <= 16'h0000;
         serialTransmitOut <= 1'b0;
         serialTransmitOe <= 1'b0;
         bits_reg <= `SSF_SIZE_MIN_M1;
      end else begin
         bits_reg <= bitsLoad;
         if (masterStart | slaveFall) begin
            txShift_reg <= emitNow ? 16'(loadWord << 1) : loadWord;
            serialTransmitOut <= emitNow & loadWord[15];
            serialTransmitOe <= 1'b1;
         end else if (emit) begin
            txShift_reg <= 16'(txShift_reg << 1);
            serialTransmitOut <= txShift_reg[15];
         end else if (running & tick & isMw & (hN == `SSF_MW_TX_OFF_H)) begin
            serialTransmitOut <= 1'b0;
         end else if (stateReg == ST_IDLE) begin
            serialTransmitOut <= 1'b0;
            // Frame-pulse floats; slave releases for shared buses
            serialTransmitOe <= masterMode & ~isTi;
         end
      end
   end

   // Receive shifter, word hand-off and timeout
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxShift_reg <= 16'h0000;
         rxWord <= 16'h0000;
         rxPush <= 1'b0;
         sclkPrev_reg <= 1'b0;
         fssPrev_reg <= 1'b1;
         tout_reg <= 16'h0000;
         rxTimeout <= 1'b0;
      end else begin
         sclkPrev_reg <= sclkSync;
         fssPrev_reg <= fssSync;
         rxShift_reg <= rxShiftNext;
         rxPush <= pushNow;
         if (pushNow) begin
            rxWord <= rxShiftNext & rxMask;
         end
         if ((stateReg == ST_IDLE) && rxFifoNotEmpty) begin
            if (tout_reg != TOUT_LAST) begin
               tout_reg <= tout_reg + 16'h0001;
            end
            rxTimeout <= (tout_reg == TOUT_LAST);
         end else begin
            tout_reg <= 16'h0000;
            rxTimeout <= 1'b0;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic [7:0] fssHigh_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fssHigh_reg <= 8'h00;
      end else begin
         fssHigh_reg <= frameSelectOut ? fssHigh_reg + 8'h01 : 8'h00;
      end
   end

   sequence idleTwo;
      (stateReg == ST_IDLE) [*2];
   endsequence

   idle_clock_a: assert property (masterMode && isSpi && $stable(frameFormat) ##0 idleTwo
      |-> serialClockOut == $past(clockPolarityBit)) else $error("idle clock level wrong");
   pulse_width_a: assert property (masterMode && isTi && $fell(frameSelectOut) && running
      |-> fssHigh_reg == 8'(2 * HALF_DIV)) else $error("frame pulse width wrong");
   pulse_idle_a: assert property (masterMode && isTi && $stable(frameFormat) ##0 idleTwo
      |-> !serialTransmitOe && !frameSelectOut && !serialClockOut) else $error("pulse idle pins wrong");
   spi_idle_a: assert property (isSpi && $stable(frameFormat) && $stable(masterMode) ##0 idleTwo
      |-> frameSelectOut && !serialTransmitOut && serialClockOe == masterMode)
      else $error("spi idle pins wrong");
   spi_start_a: assert property (masterStart && isSpi && stateReg == ST_IDLE
      |=> !frameSelectOut && serialTransmitOe && serialClockOut == $past(serialClockOut))
      else $error("spi start wrong");
   spi_low_a: assert property (masterMode && !isTi && running && $past(running) && $stable(frameFormat)
      |-> !frameSelectOut) else $error("select rose mid frame");
   pop_valid_a: assert property (txPop |-> txValid) else $error("pop without data");
   mw_quiet_a: assert property (capture && isMw |-> half_reg >= 6'h12) else $error("early receive");
   end_point_a: assert property (masterMode && rxPush |-> $past(hN) == $past(endH))
      else $error("word pushed at wrong point");
   back_phase0_a: assert property (endHit && needGap && txValid && enable
      |=> frameSelectOut ##1 stateReg == ST_GAP) else $error("no select pulse between words");
   back_phase1_a: assert property (endHit && isSpi && clockPhaseBit && txValid && enable
      |=> !frameSelectOut && running) else $error("select rose between words");
   timeout_a: assert property ($rose(rxTimeout) |-> $past(rxFifoNotEmpty) && $past(stateReg == ST_IDLE))
      else $error("timeout without idle data");
endmodule

// >>> dv/ssf_peer.sv
`timescale 1ns/1ps
module ssf_peer (
   // Pins
   input wire logic sck,
   input wire logic fss,
   input wire logic mosi,
   output logic miso,
   // Setup from the bench
   input wire logic [1:0] fmt,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [4:0] nbits,
   input wire logic [15:0] reply
);
   int k = 0;
   int c = 0;
   logic on = 1'b0;
   logic [15:0] sh = 16'h0000;
   logic [15:0] gotQ[$];

   initial miso = 1'b0;

   task automatic launch;
      if (k >= nbits && cpha && fmt == 2'h1)
         k = 0;
      if (k < nbits)
         miso = reply[nbits - 1 - k];
      else
         miso = ~miso; // Released line must not look stable
      k++;
   endtask

   task automatic capture;
      sh = {sh[14:0], mosi};
      c++;
      if (c == nbits) begin
         gotQ.push_back(sh);
         c = 0;
         sh = 16'h0000;
         on = 1'b0;
      end
   endtask

   // Select-low framings start on the falling select
   always @(negedge fss)
      if (fmt != 2'h0) begin
         c = 0;
         k = 0;
         sh = 16'h0000;
         if (fmt == 2'h1 && !cpha)
            launch;
      end
   always @(posedge fss)
      if (fmt != 2'h0)
         miso = ~miso;

   // Edge away from the rest level leads
   always @(sck)
      if (fmt == 2'h1 && fss === 1'b0) begin
         if ((sck != cpol) == !cpha)
            capture;
         else
            launch;
      end

   always @(posedge sck)
      if (fmt == 2'h0 && on)
         launch;
   always @(negedge sck)
      if (fmt == 2'h0) begin
         if (fss) begin
            on = 1'b1;
            k = 0;
            c = 0;
         end else if (on)
            capture;
      end

   // Command latched on rises, reply after one wait clock
   always @(posedge sck)
      if (fmt == 2'h2 && !fss && c < 8) begin
         sh = {sh[14:0], mosi};
         c++;
         if (c == 8)
            gotQ.push_back(sh);
      end
   always @(negedge sck)
      if (fmt == 2'h2 && !fss) begin
         k++;
         if (k >= 9 && k - 9 < nbits)
            miso = reply[nbits + 8 - k];
         else
            miso = ~miso;
      end
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk, resetn, enable, masterMode, cpol, cpha, txValid, rxFifoNotEmpty, miso;
   logic txPop, rxPush, rxTimeout, busy, sckOut, sckOe, fssOut, fssOe, txOut, txOe;
   logic [1:0] fmt;
   logic [3:0] dsm1;
   logic [15:0] txData, reply, rxWord;
   logic [15:0] txQ[$];
   logic [15:0] rxQ[$];
   int fail_count, checked, sckEdges, sckRises, fssRises, fssHigh, badOe;
   wire sckW = sckOe ? sckOut : cpol;
   wire fssW = fssOe ? fssOut : 1'b1;
   wire mosiW = txOe ? txOut : ~txOut;

   ssf_frame_engine #(.HALF_DIV(8), .TIMEOUT_CYC(8)) uut (.clk(clk), .resetn(resetn), .enable(enable),
      .masterMode(masterMode), .frameFormat(fmt), .clockPolarityBit(cpol), .clockPhaseBit(cpha),
      .dataSizeMinus1(dsm1), .txValid(txValid), .txData(txData), .txPop(txPop), .rxPush(rxPush),
      .rxWord(rxWord), .rxFifoNotEmpty(rxFifoNotEmpty), .rxTimeout(rxTimeout), .busy(busy),
      .serialClockIn(sckW), .serialClockOut(sckOut), .serialClockOe(sckOe), .frameSelectIn(fssW),
      .frameSelectOut(fssOut), .frameSelectOe(fssOe), .serialTransmitOut(txOut),
      .serialTransmitOe(txOe), .serialReceiveIn(miso));
   ssf_peer peer (.sck(sckW), .fss(fssW), .mosi(mosiW), .miso(miso), .fmt(fmt), .cpol(cpol),
      .cpha(cpha), .nbits({1'b0, dsm1} + 5'h01), .reply(reply));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Transmit FIFO model, receive capture and pin monitors
   always @(posedge clk) begin
      if (txPop === 1'b1 && txQ.size() > 0)
         void'(txQ.pop_front());
      txValid <= txQ.size() > 0;
      txData <= txQ.size() > 0 ? txQ[0] : 16'h0000;
      if (rxPush === 1'b1)
         rxQ.push_back(rxWord);
      if (fmt == 2'h1 && fssW === 1'b0 && txOe !== 1'b1)
         badOe++;
      if (fssW === 1'b1)
         fssHigh++;
   end
   always @(sckW) sckEdges++;
   always @(posedge sckW) sckRises++;
   always @(posedge fssW) fssRises++;

   task automatic check_value(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
         fail_count++;
      end
   endtask

   task automatic setup(input logic [1:0] f, input logic p, input logic h, input int n, input logic [15:0] r);
      @(posedge clk);
      fmt <= f;
      cpol <= p;
      cpha <= h;
      dsm1 <= 4'(n - 1);
      reply <= r;
      repeat (6) @(posedge clk);
      sckEdges = 0;
      sckRises = 0;
      fssRises = 0;
      fssHigh = 0;
      badOe = 0;
      rxQ.delete();
      peer.gotQ.delete();
   endtask

   task automatic run(input logic [15:0] a, input logic [15:0] b, input int words);
      int n;
      n = 0;
      txQ.push_back(a);
      if (words > 1)
         txQ.push_back(b);
      @(posedge clk);
      while ((txQ.size() > 0 || busy !== 1'b0) && n < 5000) begin
         @(posedge clk);
         n++;
      end
      repeat (40) @(posedge clk);
   endtask

   task automatic test_spi(input logic p, input logic h, input int n, input logic [15:0] a, b, r);
      logic [15:0] m;
      m = 16'((32'h1 << n) - 1);
      setup(2'h1, p, h, n, r);
      run(a, b, 2);
      check_value(rxQ.size(), 2);
      foreach (rxQ[i]) check_value(rxQ[i], r & m);
      check_value(peer.gotQ[0], a & m);
      check_value(peer.gotQ[1], b & m);
      check_value(sckEdges, 4 * n);
      check_value(sckW, p);
      check_value(fssW, 1);
      check_value(fssRises, h ? 1 : 2);
      check_value(badOe, 0);
      check_value({sckOe, txOut}, 2'b10);
      $display("spi test done");
   endtask

   task automatic test_fp(input int n, input logic [15:0] a, r);
      setup(2'h0, 1'b0, 1'b0, n, r);
      check_value({sckOut, fssOut, txOe}, 3'b000);
      run(a, a, 1);
      check_value(rxQ[0], r & 16'((32'h1 << n) - 1));
      check_value(peer.gotQ[0], a);
      check_value(fssHigh, 16);
      check_value({sckOut, fssOut, txOe}, 3'b000);
      $display("frame pulse test done");
   endtask

   task automatic test_hd(input int n, input logic [15:0] a, r);
      setup(2'h2, 1'b0, 1'b0, n, r);
      run(a, a, 1);
      check_value(peer.gotQ[0], a[7:0]);
      check_value(rxQ[0], r & 16'((32'h1 << n) - 1));
      check_value(sckRises, 9 + n);
      check_value(fssRises, 1);
      check_value(sckW, 0);
      $display("half duplex test done");
   endtask

   task automatic test_timeout;
      @(posedge clk);
      rxFifoNotEmpty <= 1'b1;
      repeat (3) @(posedge clk);
      check_value(rxTimeout, 0);
      repeat (10) @(posedge clk);
      check_value(rxTimeout, 1);
      rxFifoNotEmpty <= 1'b0;
      repeat (3) @(posedge clk);
      check_value(rxTimeout, 0);
      $display("timeout test done");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #100000;
      fail_count++;
      test_done;
   end

   initial begin
      {resetn, enable, cpol, cpha, txValid, rxFifoNotEmpty} = 6'h00;
      masterMode = 1'b1;
      fmt = 2'h1;
      dsm1 = 4'h7;
      txData = 16'h0000;
      reply = 16'h0000;
      fail_count = 0;
      checked = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      enable <= 1'b1;
      test_spi(1'b0, 1'b0, 8, 16'h00A5, 16'h005A, 16'h00C3);
      test_spi(1'b0, 1'b1, 4, 16'h0009, 16'h0006, 16'h000C);
      test_spi(1'b1, 1'b0, 16, 16'hBEEF, 16'h1234, 16'h8421);
      test_fp(12, 16'h0A5C, 16'h0C3A);
      test_hd(16, 16'h00B7, 16'hE61D);
      test_hd(4, 16'h0049, 16'h000A);
      test_timeout;
      test_done;
   end
endmodule
